//--- hdl/timsc_mask_ctrl.v
`timescale 1ns/1ns
`include "timsc_map.vh"
//--------------------------------------------------------------
// Function
// RULE_01 - Read/write 8-bit mask register at 04h
// RULE_02 - Mask register resets to all zero
// RULE_03 - Mask bits 0-5 block matching flags
// RULE_04 - Mode bit clear selects repeating mode
// RULE_05 - Repeating: read clears, next conversion re-raises
// RULE_06 - Repeating: re-raise until below hysteresis
// RULE_07 - One-time: single interrupt crossing hot limit
// RULE_08 - One-time: silent until below hysteresis
// RULE_09 - Below-hysteresis interrupt also cleared by read
// RULE_10 - Then silent until above hot again
// RULE_11 - Read clears bit, not reset next conversion
// RULE_12 - Hot flag at status bit 0
// RULE_13 - Overtemp flag at bit 5, mode bit 7
// RULE_14 - Interrupt high while any unmasked flag set
//--------------------------------------------------------------
module timsc_mask_ctrl (
    input wire i_clock,                // Clock, 250 MHz
    input wire i_srst,                 // Sync reset, active high
    input wire [7:0] i_addr,           // Register address
    input wire [7:0] i_wdata,          // Write data
    input wire i_wr,                   // Write strobe
    input wire i_rd,                   // Read strobe
    output reg [7:0] o_rdata,          // Read data, cycle after strobe
    input wire i_conv_done,            // Conversion complete pulse
    input wire i_hot_above,            // Temp above hot limit
    input wire i_hot_below_hyst,       // Temp below hot hysteresis
    input wire i_overt_above,          // Temp above overtemp limit
    input wire i_overt_below_hyst,     // Temp below overtemp hysteresis
    input wire i_board_temp_alert_in,  // Board alert event pulse
    input wire i_fan_one_tach,         // Fan one limit event pulse
    input wire i_fan_two_tach,         // Fan two limit event pulse
    input wire i_chassis_open_in,      // Chassis intrusion event pulse
    output wire o_irq,                 // Monitor interrupt, active high
    output wire o_evt_irq              // Block event interrupt
);
    //----------------------------------------------------------
    // Registers
    //----------------------------------------------------------
    reg [7:0] irq_mask_second_reg;
    reg [3:0] misc_flag_reg;
    reg [3:0] misc_flag_next;
    reg [1:0] evt_stat_reg;
    reg [1:0] evt_stat_next;
    reg [1:0] evt_mask_reg;
    wire hot_flag;
    wire overt_flag;
    wire [7:0] status2;
    wire stat_rd;
    wire [1:0] evt_raise;

    function sel;
        input [7:0] addr;
        input [7:0] target;
        begin
            sel = (addr == target);
        end
    endfunction

    assign stat_rd = i_rd && sel(i_addr, `TIMSC_ADDR_STATUS2);

    //----------------------------------------------------------
    // Temperature sources
    //----------------------------------------------------------
    timsc_temp_arm u_hot (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_one_time(irq_mask_second_reg[`TIMSC_BIT_HOT_MODE]), // [RULE_04] [RULE_12]
        .i_conv_done(i_conv_done),
        .i_above_hot(i_hot_above),
        .i_below_hyst(i_hot_below_hyst),
        .i_read_clr(stat_rd),
        .o_flag(hot_flag)
    );

    timsc_temp_arm u_overt (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_one_time(irq_mask_second_reg[`TIMSC_BIT_OVERT_MODE]), // [RULE_13]
        .i_conv_done(i_conv_done),
        .i_above_hot(i_overt_above),
        .i_below_hyst(i_overt_below_hyst),
        .i_read_clr(stat_rd),
        .o_flag(overt_flag)
    );

    //----------------------------------------------------------
    // Other sources: sticky, cleared by status read, set wins
    //----------------------------------------------------------
    always @* begin
        misc_flag_next = misc_flag_reg;
        if (stat_rd) begin
            misc_flag_next = 4'h0;
        end
        misc_flag_next = misc_flag_next | {i_chassis_open_in, i_fan_two_tach,
                                           i_fan_one_tach, i_board_temp_alert_in};
    end

    assign status2 = {2'b00, overt_flag, misc_flag_reg, hot_flag}; // [RULE_12] [RULE_13]

    //----------------------------------------------------------
    // Monitor interrupt
    //----------------------------------------------------------
    assign o_irq = |(status2[5:0] & ~irq_mask_second_reg[5:0]); // [RULE_03] [RULE_14]

    //----------------------------------------------------------
    // Block events: bit 0 mask write, bit 1 interrupt rise
    //----------------------------------------------------------
    reg irq_d_reg;
    assign evt_raise = {o_irq && !irq_d_reg, i_wr && sel(i_addr, `TIMSC_ADDR_MASK2)};

    always @* begin
        evt_stat_next = evt_stat_reg;
        if (i_wr && sel(i_addr, `TIMSC_ADDR_EVT_STAT)) begin
            evt_stat_next = evt_stat_reg & ~i_wdata[1:0];
        end
        evt_stat_next = evt_stat_next | evt_raise;
    end

    assign o_evt_irq = |(evt_stat_reg & ~evt_mask_reg);

    //----------------------------------------------------------
    // Register writes
    //----------------------------------------------------------
    always @(posedge i_clock) begin
        if (i_srst) begin
            irq_mask_second_reg <= `TIMSC_MASK2_RST; // [RULE_02]
            misc_flag_reg <= 4'h0;
            evt_stat_reg <= 2'b00;
            evt_mask_reg <= 2'b00;
            irq_d_reg <= 1'b0;
        end else begin
            if (i_wr && sel(i_addr, `TIMSC_ADDR_MASK2)) begin
                irq_mask_second_reg <= i_wdata; // [RULE_01]
            end
            if (i_wr && sel(i_addr, `TIMSC_ADDR_EVT_MASK)) begin
                evt_mask_reg <= i_wdata[1:0];
            end
            misc_flag_reg <= misc_flag_next;
            evt_stat_reg <= evt_stat_next;
            irq_d_reg <= o_irq;
        end
    end

    //----------------------------------------------------------
    // Read data, one cycle after strobe, else zero
    //----------------------------------------------------------
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `TIMSC_ADDR_MASK2: o_rdata <= irq_mask_second_reg; // [RULE_01]
                `TIMSC_ADDR_STATUS2: o_rdata <= status2;
                `TIMSC_ADDR_EVT_STAT: o_rdata <= {6'h00, evt_stat_reg};
                `TIMSC_ADDR_EVT_MASK: o_rdata <= {6'h00, evt_mask_reg};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule // timsc_mask_ctrl

//--- pkg/timsc_map.vh
`ifndef TIMSC_MAP_VH
`define TIMSC_MAP_VH
// Register offsets
`define TIMSC_ADDR_STATUS2 8'h02
`define TIMSC_ADDR_MASK2 8'h04
`define TIMSC_ADDR_EVT_STAT 8'h10
`define TIMSC_ADDR_EVT_MASK 8'h11
// Reset values
`define TIMSC_MASK2_RST 8'h00
`define TIMSC_STATUS2_RST 8'h00
`define TIMSC_EVT_RST 8'h00
// Field positions
`define TIMSC_BIT_HOT 0
`define TIMSC_BIT_BOARD 1
`define TIMSC_BIT_FAN_ONE_TACH 2
`define TIMSC_BIT_FAN_TWO_TACH 3
`define TIMSC_BIT_CHASSIS 4
`define TIMSC_BIT_OVERT 5
`define TIMSC_BIT_HOT_MODE 6
`define TIMSC_BIT_OVERT_MODE 7
`endif

//--- hdl/timsc_temp_arm.v
`timescale 1ns/1ns
`include "timsc_map.vh"
// Per-source temperature flag with repeating and one-time modes
module timsc_temp_arm (
    input wire i_clock,         // Clock
    input wire i_srst,          // Sync reset
    input wire i_one_time,      // Mode: 1 one-time, 0 repeating
    input wire i_conv_done,     // Conversion complete pulse
    input wire i_above_hot,     // Temp above hot limit
    input wire i_below_hyst,    // Temp below hysteresis
    input wire i_read_clr,      // Status register read pulse
    output wire o_flag          // Status flag
);
    reg flag_reg;
    reg flag_next;
    reg hot_side_reg;
    reg hot_side_next;
    reg set_evt;

    always @* begin
        set_evt = 1'b0;
        hot_side_next = hot_side_reg;
        if (i_conv_done) begin
            if (i_one_time) begin
                if (!hot_side_reg && i_above_hot) begin
                    set_evt = 1'b1; // [RULE_07]
                    hot_side_next = 1'b1;
                end else if (hot_side_reg && i_below_hyst) begin
                    set_evt = 1'b1; // [RULE_08] [RULE_09]
                    hot_side_next = 1'b0; // [RULE_10]
                end
            end else begin
                // Re-raise each conversion until below hysteresis
                if (i_above_hot) begin
                    hot_side_next = 1'b1;
                end else if (i_below_hyst) begin
                    hot_side_next = 1'b0;
                end
                set_evt = i_above_hot || (hot_side_reg && !i_below_hyst); // [RULE_04] [RULE_06]
            end
        end
        // Set wins over read clear
        if (set_evt) begin
            flag_next = 1'b1;
        end else if (i_read_clr) begin
            flag_next = 1'b0; // [RULE_05] [RULE_11]
        end else begin
            flag_next = flag_reg;
        end
    end

    always @(posedge i_clock) begin
        if (i_srst) begin
            flag_reg <= 1'b0;
            hot_side_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            hot_side_reg <= hot_side_next;
        end
    end

    assign o_flag = flag_reg;
endmodule // timsc_temp_arm

//--- verif/timsc_chk_sva.sv
`timescale 1ns/1ns
`include "timsc_map.vh"
module timsc_chk (
    input wire i_clock, // Clock
    input wire i_srst, // Reset
    input wire [7:0] i_addr, // Addr
    input wire [7:0] i_wdata, // Data
    input wire i_wr, // Write
    input wire i_rd, // Read
    input wire [7:0] o_rdata, // Rdata
    input wire i_conv_done, // Conv
    input wire i_hot_above, // Hot
    input wire i_board_temp_alert_in, // Evt
    input wire i_fan_one_tach, // Evt
    input wire i_fan_two_tach, // Evt
    input wire i_chassis_open_in, // Evt
    input wire o_irq, // Irq
    input wire o_evt_irq // Evt irq
);
    reg [7:0] mask_reg;
    reg [1:0] emask_reg;
    wire st_rd = i_rd && i_addr == `TIMSC_ADDR_STATUS2;
    wire quiet = !(i_conv_done || i_board_temp_alert_in || i_fan_one_tach
        || i_fan_two_tach || i_chassis_open_in);
    wire mapped = i_addr == 8'h02 || i_addr == 8'h04 || i_addr == 8'h10 || i_addr == 8'h11;
    always @(posedge i_clock) begin
        if (i_srst) begin
            mask_reg <= 8'h00;
            emask_reg <= 2'h0;
        end else if (i_wr && i_addr == `TIMSC_ADDR_MASK2) begin
            mask_reg <= i_wdata;
        end else if (i_wr && i_addr == `TIMSC_ADDR_EVT_MASK) begin
            emask_reg <= i_wdata[1:0];
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    rst_zero_a: assert property (disable iff (1'b0)
        i_srst |=> o_rdata == 8'h00 && !o_irq && !o_evt_irq) else $error("reset outputs");
    idle_rdata_a: assert property (!(i_rd && mapped) |=> o_rdata == 8'h00)
        else $error("stray read data");
    mask_rback_a: assert property (i_rd && i_addr == `TIMSC_ADDR_MASK2
        |=> o_rdata == mask_reg) else $error("mask readback");
    irq_match_a: assert property (st_rd
        |=> ((o_rdata[5:0] & ~mask_reg[5:0]) != 6'h00) == $past(o_irq)) else $error("irq vs flags");
    rep_raise_a: assert property (i_conv_done && i_hot_above && !i_wr
        && mask_reg[6] == 1'b0 && !mask_reg[0] |=> o_irq) else $error("hot not raised");
    read_clear_a: assert property (st_rd && quiet ##1 quiet ##1 st_rd && quiet
        |=> o_rdata[5:0] == 6'h00) else $error("read did not clear");
    irq_fall_a: assert property ($fell(o_irq) |-> $past(st_rd || i_wr))
        else $error("irq fell without cause");
    evt_mask_a: assert property (i_wr && i_addr == `TIMSC_ADDR_MASK2 && !emask_reg[0]
        |=> o_evt_irq) else $error("event irq missing");
    cover property (st_rd && o_irq);
    cover property (i_conv_done && mask_reg[7]);
    cover property (o_evt_irq);
endmodule // timsc_chk
bind timsc_mask_ctrl timsc_chk i_timsc_chk (.i_clock(i_clock), .i_srst(i_srst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_conv_done(i_conv_done), .i_hot_above(i_hot_above), .o_irq(o_irq), .o_evt_irq(o_evt_irq),
    .i_board_temp_alert_in(i_board_temp_alert_in), .i_fan_one_tach(i_fan_one_tach),
    .i_fan_two_tach(i_fan_two_tach), .i_chassis_open_in(i_chassis_open_in));

//--- verif/timsc_tb.sv
`timescale 1ns/1ns
`include "timsc_map.vh"
module testbench;
    reg i_clock = 0, i_srst = 1, i_wr = 0, i_rd = 0, i_conv_done = 0;
    reg [7:0] i_addr = 0, i_wdata = 0;
    reg ha = 0, hb = 1, oa = 0, ob = 1;
    reg [3:0] evt = 0;
    wire [7:0] o_rdata;
    wire o_irq, o_evt_irq;
    integer errors = 0, comparisons = 0, s, k;
    timsc_mask_ctrl i_timsc_mask_ctrl (.i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_conv_done(i_conv_done), .i_hot_above(ha), .i_hot_below_hyst(hb),
        .i_overt_above(oa), .i_overt_below_hyst(ob), .i_board_temp_alert_in(evt[0]),
        .i_fan_one_tach(evt[1]), .i_fan_two_tach(evt[2]), .i_chassis_open_in(evt[3]),
        .o_irq(o_irq), .o_evt_irq(o_evt_irq));
    initial forever #2 i_clock = ~i_clock;
    task chk(input string n, input [7:0] seen, input [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
        end
    endtask
    // Drive at a rising edge, release at the next, settle at the falling edge
    task wr(input [7:0] a, input [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(negedge i_clock);
    endtask
    // Read data stand for the cycle after the strobe
    task rdc(input [7:0] a, input [7:0] e);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        chk("rdata", o_rdata, e);
    endtask
    task cv(input integer src, input a, input b);
        @(posedge i_clock);
        i_conv_done <= 1'b1;
        ha <= !src && a;
        hb <= src || b;
        oa <= src && a;
        ob <= !src || b;
        @(posedge i_clock);
        i_conv_done <= 1'b0;
        @(negedge i_clock);
    endtask
    task pulse(input integer i);
        @(posedge i_clock);
        evt[i] <= 1'b1;
        @(posedge i_clock);
        evt <= 4'h0;
        @(negedge i_clock);
    endtask
    task rst;
        @(posedge i_clock);
        i_srst <= 1'b1;
        repeat (5) @(posedge i_clock);
        i_srst <= 1'b0;
    endtask
    task complete_run;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task t_regs;
        rdc(`TIMSC_ADDR_MASK2, 8'h00);
        wr(`TIMSC_ADDR_MASK2, 8'ha5);
        rdc(`TIMSC_ADDR_MASK2, 8'ha5);
        wr(8'h07, 8'hff);
        rdc(8'h07, 8'h00);
        rdc(`TIMSC_ADDR_MASK2, 8'ha5);
        rst;
        rdc(`TIMSC_ADDR_MASK2, 8'h00);
        $display("regs done");
    endtask
    task t_mask;
        for (s = 0; s < 6; s = s + 1) begin
            if (s == 0 || s == 5) begin
                cv(s / 5, 1'b1, 1'b0);
            end else begin
                pulse(s - 1);
            end
            chk("irq", {7'h00, o_irq}, 8'h01);
            wr(`TIMSC_ADDR_MASK2, 8'h01 << s);
            chk("irq", {7'h00, o_irq}, 8'h00);
            rdc(`TIMSC_ADDR_STATUS2, 8'h01 << s);
            wr(`TIMSC_ADDR_MASK2, 8'h00);
            chk("irq", {7'h00, o_irq}, 8'h00);
        end
        $display("mask done");
    endtask
    task t_repeat;
        cv(0, 1'b1, 1'b0);
        rdc(`TIMSC_ADDR_STATUS2, 8'h01);
        rdc(`TIMSC_ADDR_STATUS2, 8'h00);
        cv(0, 1'b0, 1'b0);
        rdc(`TIMSC_ADDR_STATUS2, 8'h01);
        cv(0, 1'b0, 1'b1);
        rdc(`TIMSC_ADDR_STATUS2, 8'h00);
        $display("repeat done");
    endtask
    task t_once;
        for (k = 0; k < 2; k = k + 1) begin
            wr(`TIMSC_ADDR_MASK2, k ? 8'h80 : 8'h40);
            cv(k, 1'b1, 1'b0);
            rdc(`TIMSC_ADDR_STATUS2, k ? 8'h20 : 8'h01);
            cv(k, 1'b1, 1'b0);
            rdc(`TIMSC_ADDR_STATUS2, 8'h00);
            cv(k, 1'b0, 1'b1);
            rdc(`TIMSC_ADDR_STATUS2, k ? 8'h20 : 8'h01);
            cv(k, 1'b0, 1'b1);
            rdc(`TIMSC_ADDR_STATUS2, 8'h00);
            cv(k, 1'b1, 1'b0);
            rdc(`TIMSC_ADDR_STATUS2, k ? 8'h20 : 8'h01);
            cv(k, 1'b0, 1'b1);
            rdc(`TIMSC_ADDR_STATUS2, k ? 8'h20 : 8'h01);
        end
        $display("once done");
    endtask
    task t_evt;
        wr(`TIMSC_ADDR_EVT_MASK, 8'h03);
        wr(`TIMSC_ADDR_EVT_STAT, 8'hff);
        wr(`TIMSC_ADDR_MASK2, 8'h00);
        chk("evt", {7'h00, o_evt_irq}, 8'h00);
        rdc(`TIMSC_ADDR_EVT_STAT, 8'h01);
        wr(`TIMSC_ADDR_EVT_MASK, 8'h02);
        chk("evt", {7'h00, o_evt_irq}, 8'h01);
        wr(`TIMSC_ADDR_EVT_STAT, 8'h01);
        chk("evt", {7'h00, o_evt_irq}, 8'h00);
        // Interrupt rise lands in event bit 1 one cycle after the flag
        pulse(3);
        rdc(`TIMSC_ADDR_STATUS2, 8'h10);
        rdc(`TIMSC_ADDR_EVT_STAT, 8'h02);
        wr(`TIMSC_ADDR_EVT_MASK, 8'h00);
        chk("evt", {7'h00, o_evt_irq}, 8'h01);
        $display("evt done");
    endtask
    initial begin
        repeat (5000) @(posedge i_clock);
        errors = errors + 1;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge i_clock);
        i_srst <= 1'b0;
        t_regs;
        t_mask;
        t_repeat;
        t_once;
        t_evt;
        complete_run;
    end
endmodule // testbench
